// ### dual_serial_host_port.sv
// Two-wire / four-wire serial port into the internal register map
`default_nettype none
module dual_serial_host_port #(
    parameter logic [7:0] TOP_ADDR = host_port_pkg::TOP_ADDR_DEFAULT,
    parameter logic [255:0] VALID_MASK = {256{1'b1}}
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic scl_mosi_i,
    input wire logic sda_sclk_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_bit_or_select_pin_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic [host_port_pkg::PTR_W-1:0] reg_addr_o,
    input wire logic [7:0] reg_rdata_i,
    output host_port_pkg::reg_write_t reg_wr_o,
    output logic spi_mode_o
);
    logic [2:0] raw;
    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    logic [2:0] s3_reg;
    logic [2:0] filt_reg;
    logic [2:0] prev_reg;
    host_port_pkg::line_evt_t ev [3];
    host_port_pkg::line_evt_t scl;
    host_port_pkg::line_evt_t sda;
    host_port_pkg::line_evt_t sel;
    logic spi_mode_reg;
    logic [1:0] sel_cnt_reg;
    host_port_pkg::link_state_t state_reg;
    host_port_pkg::phase_t phase_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic [host_port_pkg::PTR_W-1:0] register_pointer_bits_reg;
    logic over_reg;
    logic sda_oe_reg;
    logic miso_reg;
    logic reload_reg;
    host_port_pkg::reg_write_t wr_reg;
    logic start;
    logic stop;
    logic [7:0] own_addr;
    logic [7:0] spi_byte;
    logic i2c_byte_done;
    logic spi_byte_done;
    logic at_top;
    logic [host_port_pkg::PTR_W-1:0] ptr_inc;

    function automatic logic sub_valid(input logic [7:0] a);
        sub_valid = VALID_MASK[a] && (a <= TOP_ADDR);
    endfunction : sub_valid

    // Line 0 = clock/data-in pin, 1 = data/clock pin, 2 = select pin
    assign raw = {address_bit_or_select_pin_i, sda_sclk_i, scl_mosi_i};

    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_line
            // Level only follows two agreeing samples, so a one-sample spike is dropped
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    s1_reg[i] <= 1'b1;
                    s2_reg[i] <= 1'b1;
                    s3_reg[i] <= 1'b1;
                    filt_reg[i] <= 1'b1;
                    prev_reg[i] <= 1'b1;
                end
                else
                begin
                    s1_reg[i] <= raw[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i])
                    begin
                        filt_reg[i] <= s2_reg[i];
                    end
                    prev_reg[i] <= filt_reg[i];
                end
            end
            assign ev[i] = '{lvl: filt_reg[i], rise: filt_reg[i] & ~prev_reg[i],
                             fall: ~filt_reg[i] & prev_reg[i]};
        end
    endgenerate

    // In four-wire mode scl is data in and sda is the serial clock
    assign scl = ev[0];
    assign sda = ev[1];
    assign sel = ev[2];

    assign start = scl.lvl & prev_reg[0] & sda.fall;
    assign stop = scl.lvl & prev_reg[0] & sda.rise;
    assign own_addr = sel.lvl ? host_port_pkg::I2C_ADDR_HIGH : host_port_pkg::I2C_ADDR_LOW;
    assign spi_byte = {rx_reg[6:0], scl.lvl};
    assign i2c_byte_done = !spi_mode_reg && !start && !stop && state_reg == host_port_pkg::ST_RECV
                           && scl.fall && bit_cnt_reg == host_port_pkg::BYTE_BITS;
    assign spi_byte_done = spi_mode_reg && !sel.lvl && sda.rise
                           && bit_cnt_reg == host_port_pkg::BYTE_BITS - 4'h1
                           && phase_reg != host_port_pkg::PH_RDATA;
    assign at_top = register_pointer_bits_reg == TOP_ADDR;
    assign ptr_inc = at_top ? register_pointer_bits_reg : register_pointer_bits_reg + 8'h01;

    // Mode switch: sticky until reset
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            spi_mode_reg <= 1'b0;
            sel_cnt_reg <= '0;
        end
        else if (!spi_mode_reg && sel.rise)
        begin
            if (sel_cnt_reg == host_port_pkg::SEL_PULSES - 2'h1)
            begin
                spi_mode_reg <= 1'b1;
            end
            else
            begin
                sel_cnt_reg <= sel_cnt_reg + 2'h1;
            end
        end
    end

    // Transfer engine shared by both modes
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= host_port_pkg::ST_IDLE;
            phase_reg <= host_port_pkg::PH_ADDR;
            bit_cnt_reg <= '0;
            rx_reg <= '0;
            tx_reg <= '0;
            register_pointer_bits_reg <= '0;
            over_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            miso_reg <= 1'b0;
            reload_reg <= 1'b0;
            wr_reg <= '0;
        end
        else
        begin
            wr_reg.en <= 1'b0;
            reload_reg <= 1'b0;
            if (reload_reg)
            begin
                tx_reg <= reg_rdata_i;
            end
            if (spi_mode_reg)
            begin
                sda_oe_reg <= 1'b0;
                state_reg <= host_port_pkg::ST_IDLE;
                if (sel.lvl)
                begin
                    phase_reg <= host_port_pkg::PH_ADDR;
                    bit_cnt_reg <= '0;
                end
                else if (phase_reg == host_port_pkg::PH_RDATA)
                begin
                    if (sda.fall)
                    begin
                        miso_reg <= tx_reg[7];
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == host_port_pkg::BYTE_BITS - 4'h1)
                        begin
                            // Pointer settles first; new byte is fetched a cycle later
                            bit_cnt_reg <= '0;
                            register_pointer_bits_reg <= ptr_inc;
                            over_reg <= over_reg | at_top;
                            reload_reg <= 1'b1;
                        end
                    end
                end
                else if (sda.rise)
                begin
                    rx_reg <= spi_byte;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (spi_byte_done)
                    begin
                        bit_cnt_reg <= '0;
                        case (phase_reg)
                            host_port_pkg::PH_ADDR:
                            begin
                                if (spi_byte == host_port_pkg::SPI_CMD_WRITE)
                                begin
                                    phase_reg <= host_port_pkg::PH_SUB;
                                end
                                else if (spi_byte == host_port_pkg::SPI_CMD_READ)
                                begin
                                    phase_reg <= host_port_pkg::PH_RDATA;
                                    tx_reg <= reg_rdata_i;
                                end
                                else
                                begin
                                    phase_reg <= host_port_pkg::PH_SKIP;
                                end
                            end
                            host_port_pkg::PH_SUB:
                            begin
                                if (sub_valid(spi_byte))
                                begin
                                    register_pointer_bits_reg <= spi_byte;
                                    over_reg <= 1'b0;
                                    phase_reg <= host_port_pkg::PH_WDATA;
                                end
                                else
                                begin
                                    phase_reg <= host_port_pkg::PH_SKIP;
                                end
                            end
                            host_port_pkg::PH_WDATA:
                            begin
                                if (!over_reg)
                                begin
                                    wr_reg <= '{en: 1'b1, addr: register_pointer_bits_reg,
                                                data: spi_byte};
                                    register_pointer_bits_reg <= ptr_inc;
                                    over_reg <= at_top;
                                end
                            end
                            default:
                            begin
                                phase_reg <= host_port_pkg::PH_SKIP;
                            end
                        endcase
                    end
                end
            end
            else if (start)
            begin
                state_reg <= host_port_pkg::ST_RECV;
                phase_reg <= host_port_pkg::PH_ADDR;
                bit_cnt_reg <= '0;
                sda_oe_reg <= 1'b0;
            end
            else if (stop)
            begin
                state_reg <= host_port_pkg::ST_IDLE;
                sda_oe_reg <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    host_port_pkg::ST_RECV:
                    begin
                        if (scl.rise)
                        begin
                            rx_reg <= {rx_reg[6:0], sda.lvl};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (i2c_byte_done)
                        begin
                            bit_cnt_reg <= '0;
                            state_reg <= host_port_pkg::ST_IDLE;
                            case (phase_reg)
                                host_port_pkg::PH_ADDR:
                                begin
                                    if (rx_reg[7:1] == own_addr[7:1])
                                    begin
                                        sda_oe_reg <= 1'b1;
                                        state_reg <= host_port_pkg::ST_ACK;
                                        phase_reg <= rx_reg[0] ? host_port_pkg::PH_RDATA
                                                               : host_port_pkg::PH_SUB;
                                    end
                                end
                                host_port_pkg::PH_SUB:
                                begin
                                    if (sub_valid(rx_reg))
                                    begin
                                        register_pointer_bits_reg <= rx_reg;
                                        over_reg <= 1'b0;
                                        sda_oe_reg <= 1'b1;
                                        state_reg <= host_port_pkg::ST_ACK;
                                        phase_reg <= host_port_pkg::PH_WDATA;
                                    end
                                end
                                host_port_pkg::PH_WDATA:
                                begin
                                    if (!over_reg)
                                    begin
                                        wr_reg <= '{en: 1'b1, addr: register_pointer_bits_reg,
                                                    data: rx_reg};
                                        register_pointer_bits_reg <= ptr_inc;
                                        over_reg <= at_top;
                                        sda_oe_reg <= 1'b1;
                                        state_reg <= host_port_pkg::ST_ACK;
                                    end
                                end
                                default:
                                begin
                                    state_reg <= host_port_pkg::ST_IDLE;
                                end
                            endcase
                        end
                    end
                    host_port_pkg::ST_ACK:
                    begin
                        if (scl.fall)
                        begin
                            if (phase_reg == host_port_pkg::PH_RDATA)
                            begin
                                state_reg <= host_port_pkg::ST_SEND;
                                sda_oe_reg <= ~reg_rdata_i[7];
                                tx_reg <= {reg_rdata_i[6:0], 1'b0};
                                bit_cnt_reg <= '0;
                            end
                            else
                            begin
                                sda_oe_reg <= 1'b0;
                                state_reg <= host_port_pkg::ST_RECV;
                            end
                        end
                    end
                    host_port_pkg::ST_SEND:
                    begin
                        if (scl.fall)
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == host_port_pkg::BYTE_BITS - 4'h1)
                            begin
                                sda_oe_reg <= 1'b0;
                                state_reg <= host_port_pkg::ST_MACK;
                            end
                            else
                            begin
                                sda_oe_reg <= ~tx_reg[7];
                                tx_reg <= {tx_reg[6:0], 1'b0};
                            end
                        end
                    end
                    host_port_pkg::ST_MACK:
                    begin
                        if (scl.rise)
                        begin
                            if (sda.lvl)
                            begin
                                state_reg <= host_port_pkg::ST_IDLE;
                            end
                            else
                            begin
                                // Held at the top so the highest register repeats
                                register_pointer_bits_reg <= ptr_inc;
                                state_reg <= host_port_pkg::ST_ACK;
                            end
                        end
                    end
                    default:
                    begin
                        state_reg <= host_port_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_reg;
    assign miso_o = miso_reg;
    assign miso_oe_o = spi_mode_reg && !sel.lvl && phase_reg == host_port_pkg::PH_RDATA;
    assign reg_addr_o = register_pointer_bits_reg;
    assign reg_wr_o = wr_reg;
    assign spi_mode_o = spi_mode_reg;

    a_boot_two_wire: assert property (@(posedge clk_i) $past(srst_i) |-> !spi_mode_reg)
        else $error("port left reset in four-wire mode");
    a_addr_ack: assert property (@(posedge clk_i) disable iff (srst_i)
        i2c_byte_done && phase_reg == host_port_pkg::PH_ADDR && rx_reg[7:1] == own_addr[7:1]
        |=> sda_oe_reg && state_reg == host_port_pkg::ST_ACK)
        else $error("own address not acknowledged");
    a_start_restart: assert property (@(posedge clk_i) disable iff (srst_i)
        !spi_mode_reg && start
        |=> state_reg == host_port_pkg::ST_RECV && bit_cnt_reg == 4'h0)
        else $error("start did not restart reception");
    a_stop_idle: assert property (@(posedge clk_i) disable iff (srst_i)
        !spi_mode_reg && stop && !start
        |=> state_reg == host_port_pkg::ST_IDLE && !sda_oe_reg)
        else $error("stop did not idle the port");
    a_bad_sub_nack: assert property (@(posedge clk_i) disable iff (srst_i)
        i2c_byte_done && phase_reg == host_port_pkg::PH_SUB && !sub_valid(rx_reg)
        |=> !sda_oe_reg && state_reg == host_port_pkg::ST_IDLE)
        else $error("invalid subaddress acknowledged");
    a_ptr_ascend: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_reg.en
        |-> register_pointer_bits_reg == (over_reg ? wr_reg.addr : wr_reg.addr + 8'h01))
        else $error("pointer did not advance after write");
    a_write_overrun: assert property (@(posedge clk_i) disable iff (srst_i)
        i2c_byte_done && phase_reg == host_port_pkg::PH_WDATA && over_reg
        |=> !wr_reg.en && !sda_oe_reg && state_reg == host_port_pkg::ST_IDLE)
        else $error("excess write byte not discarded");
    a_spi_entry: assert property (@(posedge clk_i) disable iff (srst_i)
        !spi_mode_reg && sel.rise && sel_cnt_reg == 2'h2 |=> spi_mode_reg)
        else $error("third select edge missed");
    a_spi_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
        spi_mode_reg |=> spi_mode_reg [*3])
        else $error("four-wire mode dropped");
    a_miso_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
        sel.lvl || phase_reg != host_port_pkg::PH_RDATA |-> !miso_oe_o)
        else $error("data out driven while not reading");
    a_spi_ptr_load: assert property (@(posedge clk_i) disable iff (srst_i)
        spi_byte_done && phase_reg == host_port_pkg::PH_SUB && sub_valid(spi_byte)
        |=> register_pointer_bits_reg == $past(spi_byte))
        else $error("subaddress not loaded");
    a_no_drive_spi: assert property (@(posedge clk_i) disable iff (srst_i)
        spi_mode_reg |=> !sda_oe_reg)
        else $error("data pin driven in four-wire mode");

    c_i2c_write: cover property (@(posedge clk_i) !spi_mode_reg && wr_reg.en);
    c_i2c_read: cover property (@(posedge clk_i) state_reg == host_port_pkg::ST_SEND);
    c_spi_entry: cover property (@(posedge clk_i) $rose(spi_mode_reg));
    c_spi_read: cover property (@(posedge clk_i) miso_oe_o && reload_reg);
endmodule : dual_serial_host_port
`default_nettype wire

// ### dual_serial_host_port_tb.sv
// Self-checking bench for the dual-mode serial host port
`default_nettype none
module dual_serial_host_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] TOP = 8'h1f;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic scl_mosi, sda_sclk, sel, sda_o, sda_oe, miso, miso_oe, spi_mode, ack;
    logic [7:0] reg_addr, rdata, r, sub;
    host_port_pkg::reg_write_t wr;
    logic [7:0] map [256];
    logic [7:0] exp_map [256];
    logic [15:0] seed = 16'hd1d8;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    dual_serial_host_port #(.TOP_ADDR(TOP), .VALID_MASK(~(256'h1 << 5))) uut (.clk_i(clk),
        .srst_i(srst), .scl_mosi_i(scl_mosi), .sda_sclk_i(sda_sclk), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .address_bit_or_select_pin_i(sel), .miso_o(miso),
        .miso_oe_o(miso_oe), .reg_addr_o(reg_addr), .reg_rdata_i(rdata), .reg_wr_o(wr),
        .spi_mode_o(spi_mode));
    host_master_model u_host (.clk_i(clk), .sda_oe_i(sda_oe), .miso_i(miso),
        .miso_oe_i(miso_oe), .scl_mosi_o(scl_mosi), .sda_sclk_o(sda_sclk), .sel_o(sel));
    assign rdata = map[reg_addr];
    initial forever #5 clk = ~clk;
    always @(posedge clk)
    begin
        if (wr.en) map[wr.addr] <= wr.data;
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // Acks expected per byte in e: address, subaddress, then data bytes
    task automatic i2c_wr(input logic [7:0] ad, input logic [7:0] s, input int n,
        input logic [5:0] e);
        logic [7:0] d;
        u_host.start();
        for (int i = 0; i < n + 2; i++)
        begin
            d = (i == 0) ? ad : (i == 1) ? s : rnd();
            u_host.xfer(d, 1'b0, r, ack);
            chk("i2c ack", {7'h0, e[i]}, {7'h0, ack});
            if (i > 1 && e[i]) exp_map[s + i - 2] = d;
            if (!e[i]) break;
        end
        u_host.stop();
    endtask : i2c_wr
    task automatic i2c_rd(input logic [7:0] s, input int n);
        u_host.start();
        u_host.xfer(8'hd6, 1'b0, r, ack);
        u_host.xfer(s, 1'b0, r, ack);
        u_host.start();
        u_host.xfer(8'hd7, 1'b0, r, ack);
        chk("rd ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++)
        begin
            u_host.xfer(8'hff, i < n - 1, r, ack);
            chk("i2c rd", exp_map[(s + i > TOP) ? TOP : s + i], r);
        end
        u_host.stop();
    endtask : i2c_rd
    task automatic spi_tx(input logic w, input logic [7:0] s, input int n);
        logic [7:0] d;
        u_host.sel_set(1'b0);
        u_host.spi_byte(host_port_pkg::SPI_CMD_WRITE, r);
        u_host.spi_byte(s, r);
        if (!w)
        begin
            u_host.sel_set(1'b1);
            u_host.sel_set(1'b0);
            u_host.spi_byte(host_port_pkg::SPI_CMD_READ, r);
        end
        for (int i = 0; i < n; i++)
        begin
            d = rnd();
            u_host.spi_byte(d, r);
            if (w) exp_map[s + i] = d;
            else chk("spi rd", exp_map[s + i], r);
            chk("miso oe", {7'h0, ~w}, {7'h0, miso_oe});
        end
        u_host.sel_set(1'b1);
        chk("miso oe", 8'h00, {7'h0, miso_oe});
    endtask : spi_tx
    initial
    begin
        foreach (map[i])
        begin
            map[i] = 8'h00;
            exp_map[i] = 8'h00;
        end
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        chk("mode", 8'h00, {7'h0, spi_mode});
        sub = 8'h08 + (rnd() & 8'h0f);
        i2c_wr(8'hd6, sub, 3, 6'b011111);
        i2c_rd(sub, 4);
        i2c_wr(8'hd4, 8'h01, 1, 6'b000000);
        i2c_wr(8'hd6, 8'h05, 1, 6'b000001);
        u_host.start();
        repeat (4) u_host.bit_io(1'b0, ack);
        i2c_wr(8'hd6, 8'h02, 1, 6'b000111);
        i2c_wr(8'hd6, TOP - 8'h01, 3, 6'b001111);
        i2c_rd(TOP - 8'h01, 3);
        u_host.enter_spi();
        chk("mode", 8'h01, {7'h0, spi_mode});
        spi_tx(1'b1, 8'h10, 3);
        spi_tx(1'b0, 8'h10, 3);
        for (int i = 0; i <= TOP + 1; i++) chk("map", exp_map[i], map[i]);
        chk("mode", 8'h01, {7'h0, spi_mode});
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        chk("mode", 8'h00, {7'h0, spi_mode});
        report_and_stop();
    end
endmodule : dual_serial_host_port_tb
`default_nettype wire

// ### host_master_model.sv
// Host master model driving the shared two-wire / four-wire pins
`default_nettype none
module host_master_model (
    input wire logic clk_i,
    input wire logic sda_oe_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic scl_mosi_o,
    output logic sda_sclk_o,
    output logic sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HP = 6;
    logic pull = 1'b0;
    logic scl = 1'b1;
    logic mosi = 1'b0;
    logic sclk = 1'b0;
    logic spi = 1'b0;
    logic miso_w;
    initial sel_o = 1'b1;
    // Open drain with pull-up; the four-wire clock stands low between frames, the two-wire clock stands high after a stop
    assign sda_sclk_o = spi ? sclk : ~(pull | sda_oe_i);
    assign scl_mosi_o = spi ? mosi : scl;
    // Released line shows the inverse of the held data bit, never the stale bit itself
    assign miso_w = miso_oe_i ? miso_i : ~miso_i;
    task automatic hp();
        repeat (HP) @(posedge clk_i);
    endtask : hp
    task automatic bit_io(input logic b, output logic r);
        hp();
        pull <= ~b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda_sclk_o;
        scl <= 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] r,
        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(~m_ack, ack);
        ack = ~ack;
    endtask : xfer
    task automatic start();
        hp();
        pull <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        pull <= 1'b1;
        hp();
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        hp();
        pull <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        pull <= 1'b0;
        hp();
    endtask : stop
    task automatic sel_set(input logic v);
        hp();
        sel_o <= v;
        hp();
    endtask : sel_set
    task automatic enter_spi();
        repeat (3)
        begin
            sel_set(1'b0);
            sel_set(1'b1);
        end
        spi <= 1'b1;
    endtask : enter_spi
    task automatic spi_byte(input logic [7:0] d, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
        begin
            mosi <= d[i];
            hp();
            sclk <= 1'b1;
            r[i] = miso_w;
            hp();
            // Every other high phase one clock longer: 125 ns per bit on average
            if (i % 2 == 1)
            begin
                @(posedge clk_i);
            end
            sclk <= 1'b0;
        end
    endtask : spi_byte
endmodule : host_master_model
`default_nettype wire

// ### host_port_pkg.sv
// Constants and types for the dual-mode serial host port
`default_nettype none
package host_port_pkg;
    localparam int PTR_W = 8;
    localparam logic [7:0] I2C_ADDR_LOW = 8'hd4;
    localparam logic [7:0] I2C_ADDR_HIGH = 8'hd6;
    localparam logic [7:0] SPI_CMD_WRITE = 8'hd4;
    localparam logic [7:0] SPI_CMD_READ = 8'hd5;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] SEL_PULSES = 2'h3;
    localparam logic [7:0] TOP_ADDR_DEFAULT = 8'h7f;

    typedef struct packed {
        logic en;
        logic [PTR_W-1:0] addr;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
    } line_evt_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RECV = 5'b00010,
        ST_ACK = 5'b00100,
        ST_SEND = 5'b01000,
        ST_MACK = 5'b10000
    } link_state_t;

    typedef enum logic [4:0] {
        PH_ADDR = 5'b00001,
        PH_SUB = 5'b00010,
        PH_WDATA = 5'b00100,
        PH_RDATA = 5'b01000,
        PH_SKIP = 5'b10000
    } phase_t;
endpackage : host_port_pkg
`default_nettype wire
